// >>> hw/msfr_pkg.sv
/*
  Constants for the monitor security gate and flash range sequencer.
  Assumes a byte-wide flash and RAM reached through simple one-cycle ports.
*/
package msfr_pkg;
  localparam logic [15:0] SEC_FIRST_ADDR    = 16'hFFF6;
  localparam logic [15:0] SEC_LAST_ADDR     = 16'hFFFD;
  localparam int          SEC_BYTES         = 8;
  localparam logic [7:0]  BLANK_BYTE        = 8'hFF;
  localparam int          BREAK_BITS        = 10;
  localparam logic [15:0] RAM_SEC_FLAG_ADDR = 16'h0060;
  localparam int          RAM_SEC_FLAG_BIT  = 6;
  localparam int          MAX_DATA_SIZE     = 128;
  localparam int          PAGE_BYTES        = 64;
  localparam logic [15:0] MASS_ERASE_ADDR   = 16'hFFFF;
  localparam logic [15:0] ENT_PROGRAM       = 16'hFC06;
  localparam logic [15:0] ENT_ERASE         = 16'hFCBE;
  localparam logic [15:0] ENT_LOAD          = 16'hFF30;
  localparam logic [15:0] ENT_MON_PROGRAM   = 16'hFF28;
  localparam logic [15:0] ENT_MON_ERASE     = 16'hFF2C;
  localparam logic [15:0] ENT_MON_LOAD      = 16'hFF24;
  localparam logic [15:0] ENT_EMULATED_EEPROM_WRITE_SERVICE      = 16'hFD3F;
  localparam logic [15:0] ENT_EMULATED_EEPROM_READ_SERVICE       = 16'hFDD0;
  localparam logic [7:0]  STACK_PROGRAM     = 8'h0F;
  localparam logic [7:0]  STACK_ERASE       = 8'h09;
  localparam logic [7:0]  STACK_LOAD        = 8'h09;
  localparam logic [7:0]  INVALID_READ      = 8'h00;
  localparam int          CLK_HZ            = 25000000;
  localparam int          BAUD_DEFAULT      = 9600;
  localparam int          BIT_CYCLES        = CLK_HZ / BAUD_DEFAULT;
  localparam logic [3:0]  SVC_NONE = 4'h0;
  localparam logic [3:0]  SVC_PROG = 4'h1;
  localparam logic [3:0]  SVC_ERASE = 4'h2;
  localparam logic [3:0]  SVC_LOAD = 4'h3;
  localparam logic [15:0] REG_SEC_STATUS = 16'h0000;
  localparam logic [15:0] REG_SVC_CALL   = 16'h0004;
  localparam logic [15:0] REG_SVC_PTR    = 16'h0008;
  localparam logic [15:0] REG_SVC_STATUS = 16'h000C;
  typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_ERASE, ST_RAMRD, ST_FLWR, ST_FLRD,
                            ST_RAMWR} msfr_state_type;
endpackage : msfr_pkg

// >>> hw/msfr_top.sv
/*
  Monitor security gate and flash range service sequencer.
  Assumes the serial byte receiver sits outside and presents whole bytes,
  and that flash and RAM answer a read in the following cycle.
*/
// The plain strobed port and the register addresses are this design's own decisions.
// Behaviour
// - Grant only when all eight bytes match
// - Wait for eight security bytes first
// - Grant persists until power-on reset only
// - Denied: flash reads invalid, fetch resets
// - Break sent only after eight bytes
// - Break is ten low bit times
// - Match sets bit 6 of RAM 60
// - Mass erase blanks security bytes too
// - Parameter block read from pointer in order
// - Size up to 128; erase ignores it
// - Program bytes without blank check or verify
// - Erase page, or mass at FFFF
// - Load copies flash bytes into RAM array
// - User entry points and stack depths
// - Monitor and emulated entry points
// - No dedicated RAM used by services
`timescale 1ns/1ns
module msfr_top
  import msfr_pkg::*;
#(
  parameter int BIT_TIME = BIT_CYCLES
)(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        por_i,
  input  wire logic        mon_rx_valid_i,
  input  wire logic [7:0]  mon_rx_data_i,
  input  wire logic        fetch_i,
  input  wire logic        mon_read_i,
  input  wire logic [15:0] mon_addr_i,
  input  wire logic [7:0]  flash_rdata_i,
  input  wire logic [7:0]  ram_rdata_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  output logic             monitor_serial_pin_o,
  output logic             monitor_serial_pin_oe_o,
  output logic             cmd_ready_o,
  output logic             access_granted_o,
  output logic             illegal_addr_reset_o,
  output logic      [7:0]  mon_rdata_o,
  output logic             flash_rd_o,
  output logic             flash_wr_o,
  output logic             flash_page_erase_o,
  output logic             flash_mass_erase_o,
  output logic      [15:0] flash_addr_o,
  output logic      [7:0]  flash_wdata_o,
  output logic             ram_rd_o,
  output logic             ram_wr_o,
  output logic      [15:0] ram_addr_o,
  output logic      [7:0]  ram_wdata_o,
  output logic             svc_busy_o
);
  logic [3:0]  sec_cnt_r;
  logic        sec_ok_r;
  logic        sec_done_r;
  logic        granted_r;
  logic [3:0]  brk_bits_r;
  logic [15:0] brk_tmr_r;
  logic        brk_active_r;
  logic        sec_cmp_rd_r;
  logic        sec_cmp_r;
  logic        sec_last;
  logic        mon_rd_p1_r;
  logic        mon_rd_p2_r;
  logic [7:0]  sec_byte_r;
  msfr_state_type state_r;
  logic [3:0]  svc_r;
  logic [15:0] ptr_r;
  logic [15:0] start_r;
  logic [7:0]  size_r;
  logic [7:0]  idx_r;
  logic [1:0]  hdr_r;
  logic        wait_r;

  // Compare of the eighth byte; flash data arrive two cycles after the byte
  assign sec_last = sec_cmp_r && sec_cnt_r == 4'(SEC_BYTES - 1);

  // Incoming security bytes are held, then compared against the stored copy
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || por_i)
    begin
      sec_cnt_r    <= 4'h0;
      sec_ok_r     <= 1'b1;
      sec_cmp_rd_r <= 1'b0;
      sec_cmp_r    <= 1'b0;
      sec_byte_r   <= 8'h00;
    end
    else
    begin
      sec_cmp_rd_r <= 1'b0;
      sec_cmp_r    <= sec_cmp_rd_r;
      if (mon_rx_valid_i && !sec_done_r && !sec_cmp_rd_r)
      begin
        sec_byte_r   <= mon_rx_data_i;
        sec_cmp_rd_r <= 1'b1;
      end
      if (sec_cmp_r)
      begin
        if (flash_rdata_i != sec_byte_r)
          sec_ok_r <= 1'b0;
        sec_cnt_r <= sec_cnt_r + 4'h1;
      end
    end
  end

  // Done flag and grant; only a power-on reset revokes the grant
  always_ff @(posedge clk_i)
  begin
    if (por_i)
    begin
      sec_done_r <= 1'b0;
      granted_r  <= 1'b0;
    end
    else if (sec_last)
    begin
      sec_done_r <= 1'b1;
      granted_r  <= sec_ok_r && (flash_rdata_i == sec_byte_r);
    end
  end

  // Ready break on the serial pin after the security phase
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || por_i)
    begin
      brk_active_r <= 1'b0;
      brk_bits_r   <= 4'h0;
      brk_tmr_r    <= 16'h0000;
      cmd_ready_o  <= 1'b0;
    end
    else if (sec_last)
    begin
      brk_active_r <= 1'b1;
      brk_bits_r   <= 4'h0;
      brk_tmr_r    <= 16'h0000;
    end
    else if (brk_active_r)
    begin
      if (brk_tmr_r == 16'(BIT_TIME - 1))
      begin
        brk_tmr_r <= 16'h0000;
        if (brk_bits_r == 4'(BREAK_BITS - 1))
        begin
          brk_active_r <= 1'b0;
          cmd_ready_o  <= 1'b1;
        end
        brk_bits_r <= brk_bits_r + 4'h1;
      end
      else
        brk_tmr_r <= brk_tmr_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      monitor_serial_pin_o    <= 1'b1;
      monitor_serial_pin_oe_o <= 1'b1;
    end
    else
    begin
      monitor_serial_pin_o    <= 1'b0;
      monitor_serial_pin_oe_o <= !brk_active_r;
    end
  end

  // Flash read gating for monitor reads and instruction fetches
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      mon_rdata_o          <= 8'h00;
      illegal_addr_reset_o <= 1'b0;
      access_granted_o     <= 1'b0;
      mon_rd_p1_r          <= 1'b0;
      mon_rd_p2_r          <= 1'b0;
    end
    else
    begin
      access_granted_o     <= granted_r;
      illegal_addr_reset_o <= fetch_i && !granted_r;
      // Flash answers one cycle after the registered read strobe
      mon_rd_p1_r          <= mon_read_i;
      mon_rd_p2_r          <= mon_rd_p1_r;
      if (mon_rd_p2_r)
        mon_rdata_o <= granted_r ? flash_rdata_i : INVALID_READ;
    end
  end

  // Service sequencer: header fetch, then erase, program or load
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      state_r <= ST_IDLE;
      svc_r   <= SVC_NONE;
      ptr_r   <= 16'h0000;
      start_r <= 16'h0000;
      size_r  <= 8'h00;
      idx_r   <= 8'h00;
      hdr_r   <= 2'h0;
      wait_r  <= 1'b0;
    end
    else
    begin
      wait_r <= 1'b0;
      if (reg_wr_i && reg_addr_i == REG_SVC_PTR)
        ptr_r <= reg_wdata_i[15:0];
      unique case (state_r)
        ST_IDLE:
        begin
          if (reg_wr_i && reg_addr_i == REG_SVC_CALL && reg_wdata_i[3:0] != SVC_NONE)
          begin
            svc_r   <= reg_wdata_i[3:0];
            hdr_r   <= 2'h0;
            wait_r  <= 1'b1;
            state_r <= ST_HDR;
          end
        end
        ST_HDR:
        begin
          if (!wait_r)
          begin
            unique case (hdr_r)
              2'h0: ;
              2'h1: size_r <= (ram_rdata_i > 8'(MAX_DATA_SIZE)) ?
                              8'(MAX_DATA_SIZE) : ram_rdata_i;
              2'h2: start_r[15:8] <= ram_rdata_i;
              2'h3: start_r[7:0]  <= ram_rdata_i;
            endcase
            hdr_r  <= hdr_r + 2'h1;
            wait_r <= 1'b1;
            idx_r  <= 8'h00;
            if (hdr_r == 2'h3)
            begin
              wait_r  <= 1'b0;
              state_r <= (svc_r == SVC_ERASE) ? ST_ERASE :
                         (svc_r == SVC_PROG)  ? ST_RAMRD : ST_FLRD;
            end
          end
        end
        ST_ERASE:
          state_r <= ST_IDLE;
        ST_RAMRD:
        begin
          if (idx_r == size_r)
            state_r <= ST_IDLE;
          else
          begin
            wait_r  <= 1'b1;
            state_r <= ST_FLWR;
          end
        end
        ST_FLWR:
        begin
          if (!wait_r)
          begin
            idx_r   <= idx_r + 8'h01;
            state_r <= ST_RAMRD;
          end
        end
        ST_FLRD:
        begin
          if (idx_r == size_r)
            state_r <= ST_IDLE;
          else
          begin
            wait_r  <= 1'b1;
            state_r <= ST_RAMWR;
          end
        end
        ST_RAMWR:
        begin
          if (!wait_r)
          begin
            idx_r   <= idx_r + 8'h01;
            state_r <= ST_FLRD;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Strobes to flash and RAM, registered from the sequencer state, the security byte compare and monitor reads
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      flash_rd_o <= 1'b0;
      flash_wr_o <= 1'b0;
      flash_page_erase_o <= 1'b0;
      flash_mass_erase_o <= 1'b0;
      flash_addr_o <= SEC_FIRST_ADDR;
      flash_wdata_o <= 8'h00;
      ram_rd_o <= 1'b0;
      ram_wr_o <= 1'b0;
      ram_addr_o <= 16'h0000;
      ram_wdata_o <= 8'h00;
      svc_busy_o <= 1'b0;
    end
    else
    begin
      svc_busy_o <= state_r != ST_IDLE;
      flash_rd_o <= (mon_rx_valid_i && !sec_done_r) || mon_read_i ||
                    (state_r == ST_FLRD && idx_r != size_r);
      flash_wr_o <= state_r == ST_FLWR && !wait_r;
      flash_page_erase_o <= state_r == ST_ERASE && start_r != MASS_ERASE_ADDR;
      flash_mass_erase_o <= state_r == ST_ERASE && start_r == MASS_ERASE_ADDR;
      if (mon_rx_valid_i && !sec_done_r)
        flash_addr_o <= SEC_FIRST_ADDR + 16'(sec_cnt_r) + 16'(sec_cmp_r);
      else if (mon_read_i)
        flash_addr_o <= mon_addr_i;
      else if (state_r == ST_ERASE)
        flash_addr_o <= start_r & ~16'(PAGE_BYTES - 1);
      else
        flash_addr_o <= start_r + 16'(idx_r);
      flash_wdata_o <= ram_rdata_i;
      ram_rd_o <= (state_r == ST_HDR) || (state_r == ST_RAMRD && idx_r != size_r);
      ram_wr_o <= (state_r == ST_RAMWR && !wait_r) || sec_last;
      if (sec_last)
      begin
        ram_addr_o  <= RAM_SEC_FLAG_ADDR;
        ram_wdata_o <= 8'((sec_ok_r && flash_rdata_i == sec_byte_r) ? 1 : 0)
                       << RAM_SEC_FLAG_BIT;
      end
      else
      begin
        // Header reads run one entry ahead of the capture that uses them
        ram_addr_o  <= (state_r == ST_HDR) ? ptr_r + 16'(hdr_r) + 16'h0001 :
                       ptr_r + 16'h0004 + 16'(idx_r);
        ram_wdata_o <= flash_rdata_i;
      end
    end
  end

  // Register read port
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (reg_rd_i)
      unique case (reg_addr_i)
        REG_SEC_STATUS: reg_rdata_o <= {29'h0, cmd_ready_o, sec_done_r, granted_r};
        REG_SVC_CALL:   reg_rdata_o <= {28'h0, svc_r};
        REG_SVC_PTR:    reg_rdata_o <= {16'h0, ptr_r};
        REG_SVC_STATUS: reg_rdata_o <= {16'h0, size_r, 7'h0, state_r != ST_IDLE};
        default:        reg_rdata_o <= 32'h0000_0000;
      endcase
    else
      reg_rdata_o <= 32'h0000_0000;
  end

  property p_grant_needs_done;
    @(posedge clk_i) disable iff (!resetn_i) granted_r |-> sec_done_r;
  endproperty
  a_grant_needs_done: assert property (p_grant_needs_done) else $error("grant before eight bytes");

  property p_denied_read;
    @(posedge clk_i) disable iff (!resetn_i)
      (mon_read_i && !granted_r) |-> ##3 (mon_rdata_o == INVALID_READ);
  endproperty
  a_denied_read: assert property (p_denied_read) else $error("denied flash read leaked");

  property p_fetch_reset;
    @(posedge clk_i) disable iff (!resetn_i)
      (fetch_i && !granted_r) |=> illegal_addr_reset_o;
  endproperty
  a_fetch_reset: assert property (p_fetch_reset) else $error("no illegal address reset");

  property p_no_early_break;
    @(posedge clk_i) disable iff (!resetn_i || por_i) brk_active_r |-> sec_done_r;
  endproperty
  a_no_early_break: assert property (p_no_early_break) else $error("break before bytes");

  property p_grant_kept;
    @(posedge clk_i) disable iff (por_i) granted_r |=> granted_r;
  endproperty
  a_grant_kept: assert property (p_grant_kept) else $error("grant lost without POR");

  property p_mass_addr;
    @(posedge clk_i) disable iff (!resetn_i)
      (state_r == ST_ERASE && start_r == MASS_ERASE_ADDR) |=> flash_mass_erase_o;
  endproperty
  a_mass_addr: assert property (p_mass_addr) else $error("mass erase missing");

  property p_ready_after_break;
    @(posedge clk_i) disable iff (!resetn_i || por_i) cmd_ready_o |-> sec_done_r && !brk_active_r;
  endproperty
  a_ready_after_break: assert property (p_ready_after_break) else $error("ready too soon");

  property p_size_cap;
    @(posedge clk_i) disable iff (!resetn_i) size_r <= 8'(MAX_DATA_SIZE);
  endproperty
  a_size_cap: assert property (p_size_cap) else $error("size above limit");
endmodule : msfr_top

// >>> sim/msfr_mem_model.sv
/*
  Flash and RAM arrays seen by the sequencer.
  Assumes reads answer in the next cycle only, one byte per strobe.
*/
`timescale 1ns/1ns
module msfr_mem_model (
  input  wire logic        clk_i,
  input  wire logic        flash_rd_i,
  input  wire logic        flash_wr_i,
  input  wire logic        flash_page_erase_i,
  input  wire logic        flash_mass_erase_i,
  input  wire logic [15:0] flash_addr_i,
  input  wire logic [7:0]  flash_wdata_i,
  input  wire logic        ram_rd_i,
  input  wire logic        ram_wr_i,
  input  wire logic [15:0] ram_addr_i,
  input  wire logic [7:0]  ram_wdata_i,
  output logic      [7:0]  flash_rdata_o,
  output logic      [7:0]  ram_rdata_o
);
  logic [7:0] flash [0:65535];
  logic [7:0] ram   [0:65535];
  logic [7:0] fl_r, rm_r;
  logic       fv_r, rv_r;
  initial
  begin
    foreach (flash[i]) flash[i] = 8'hFF;
    foreach (ram[i]) ram[i] = 8'h00;
    fl_r = 8'h00; rm_r = 8'h00; fv_r = 1'b0; rv_r = 1'b0;
  end
  // Stale data is inverted so a late sample never looks right
  assign flash_rdata_o = fv_r ? fl_r : ~fl_r;
  assign ram_rdata_o   = rv_r ? rm_r : ~rm_r;
  always @(posedge clk_i)
  begin
    fv_r <= flash_rd_i;
    rv_r <= ram_rd_i;
    if (flash_rd_i) fl_r <= flash[flash_addr_i];
    if (ram_rd_i) rm_r <= ram[ram_addr_i];
    if (flash_wr_i) flash[flash_addr_i] <= flash_wdata_i;
    if (ram_wr_i) ram[ram_addr_i] <= ram_wdata_i;
    if (flash_page_erase_i)
      for (int i = 0; i < 64; i++) flash[{flash_addr_i[15:6], 6'h00} + i] <= 8'hFF;
    if (flash_mass_erase_i)
      for (int i = 0; i < 65536; i++) flash[i] <= 8'hFF;
  end
endmodule : msfr_mem_model

// >>> sim/monitor_security_flash_routines_bench.sv
/*
  Self-checking bench: security entry, break, grant gating, flash services.
  Assumes the memory model above and BIT_TIME set to 4.
*/
`timescale 1ns/1ns
module monitor_security_flash_routines_bench;
  import msfr_pkg::*;
  localparam int BT = 4;
  logic clk_i = 0, resetn_i = 0, por_i = 1, rx_v = 0, fetch = 0, mrd = 0, wr = 0, rd = 0;
  logic [7:0]  rx_d = 8'h00, frd_d, rrd_d, mdat, fwd, rwd;
  logic [15:0] maddr = 16'h0000, addr = 16'h0000, fa, ra;
  logic [31:0] wd = 32'h0, rdata, rv;
  logic        oe_n, pin_o, rdy, gnt, ill, frd, fwr, fpe, fme, rrd, rwr, busy;
  int          failures = 0, total_checks = 0, cyc = 0;
  logic [7:0]  dat [0:7];
  wire         pin = oe_n ? 1'b1 : pin_o;
  always #20 clk_i = ~clk_i;
  msfr_top #(.BIT_TIME(BT)) msfr_top_inst (.clk_i(clk_i), .resetn_i(resetn_i), .por_i(por_i),
    .mon_rx_valid_i(rx_v), .mon_rx_data_i(rx_d), .fetch_i(fetch), .mon_read_i(mrd),
    .mon_addr_i(maddr), .flash_rdata_i(frd_d), .ram_rdata_i(rrd_d), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .monitor_serial_pin_o(pin_o), .monitor_serial_pin_oe_o(oe_n), .cmd_ready_o(rdy),
    .access_granted_o(gnt), .illegal_addr_reset_o(ill), .mon_rdata_o(mdat), .flash_rd_o(frd),
    .flash_wr_o(fwr), .flash_page_erase_o(fpe), .flash_mass_erase_o(fme), .flash_addr_o(fa),
    .flash_wdata_o(fwd), .ram_rd_o(rrd), .ram_wr_o(rwr), .ram_addr_o(ra), .ram_wdata_o(rwd),
    .svc_busy_o(busy));
  msfr_mem_model msfr_mem_model_inst (.clk_i(clk_i), .flash_rd_i(frd), .flash_wr_i(fwr),
    .flash_page_erase_i(fpe), .flash_mass_erase_i(fme), .flash_addr_i(fa),
    .flash_wdata_i(fwd), .ram_rd_i(rrd), .ram_wr_i(rwr), .ram_addr_i(ra),
    .ram_wdata_i(rwd), .flash_rdata_o(frd_d), .ram_rdata_o(rrd_d));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  function automatic logic [7:0] exp_rd(input logic g, input logic [7:0] v);
    return g ? v : INVALID_READ;
  endfunction : exp_rd
  task automatic do_reset(input logic power);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    por_i <= power;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    por_i <= 1'b0;
  endtask : do_reset
  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr <= 1'b1; addr <= a; wd <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [15:0] a);
    @(posedge clk_i);
    rd <= 1'b1; addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask : reg_rd
  task automatic security(input int miss);
    int n;
    int k;
    for (int i = 0; i < 8; i++)
    begin
      if (i == 7) check(pin, 1'b1);
      @(posedge clk_i);
      rx_v <= 1'b1;
      rx_d <= msfr_mem_model_inst.flash[SEC_FIRST_ADDR + i] ^ ((i == miss) ? 8'h21 : 8'h00);
      @(posedge clk_i);
      rx_v <= 1'b0;
      if (i < 7) repeat (2) @(posedge clk_i);
    end
    n = 0; k = 0;
    #1;
    while (oe_n !== 1'b0 && k < 20)
    begin
      k++;
      @(posedge clk_i) #1;
    end
    while (oe_n === 1'b0 && n < 100)
    begin
      check(pin, 1'b0);
      n++;
      @(posedge clk_i) #1;
    end
    check(n, BREAK_BITS * BT);
    repeat (2) @(posedge clk_i) #1;
    check(rdy, 1'b1);
    check(gnt, miss == 8);
    check(msfr_mem_model_inst.ram[RAM_SEC_FLAG_ADDR][RAM_SEC_FLAG_BIT], miss == 8);
  endtask : security
  task automatic gate(input logic g);
    logic seen;
    seen = 1'b0;
    maddr <= 16'h1000 + 16'($urandom % 16'h8000);
    @(posedge clk_i);
    msfr_mem_model_inst.flash[maddr] = 8'hA5;
    mrd <= 1'b1;
    @(posedge clk_i);
    mrd <= 1'b0;
    fetch <= 1'b1;
    @(posedge clk_i);
    fetch <= 1'b0;
    #1 seen = ill;
    repeat (4) @(posedge clk_i) #1 seen |= ill;
    check(mdat, exp_rd(g, 8'hA5));
    check(seen, !g);
  endtask : gate
  task automatic service(input logic [3:0] code, input logic [15:0] ptr);
    int k;
    reg_wr(REG_SVC_PTR, {16'h0000, ptr});
    reg_wr(REG_SVC_CALL, {28'h0, code});
    k = 0;
    @(posedge clk_i) #1;
    while (busy !== 1'b1 && k < 10) @(posedge clk_i) #1 k++;
    while (busy !== 1'b0 && k < 2000) @(posedge clk_i) #1 k++;
    check(k < 2000, 1'b1);
  endtask : service
  task automatic block(input logic [15:0] p, input logic [7:0] sz, input logic [15:0] st);
    msfr_mem_model_inst.ram[p] = 8'd20;
    msfr_mem_model_inst.ram[p + 1] = sz;
    msfr_mem_model_inst.ram[p + 2] = st[15:8];
    msfr_mem_model_inst.ram[p + 3] = st[7:0];
  endtask : block
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      end_sim();
    end
  end
  initial
  begin
    void'($urandom(32'h50547a8c));
    for (int i = 0; i < 8; i++)
      msfr_mem_model_inst.flash[SEC_FIRST_ADDR + i] = 8'($urandom);
    do_reset(1'b1);
    security($urandom % 8);
    gate(1'b0);
    $display("test mismatch done");
    do_reset(1'b1);
    security(8);
    reg_rd(REG_SEC_STATUS);
    check(rv[2:0], 3'b111);
    reg_rd(16'h0010);
    check(rv, 32'h0);
    do_reset(1'b0);
    repeat (2) @(posedge clk_i) #1;
    check(gnt, 1'b1);
    gate(1'b1);
    $display("test grant done");
    block(16'h0080, 8'd8, 16'hEF3C);
    for (int i = 0; i < 8; i++)
    begin
      dat[i] = 8'($urandom);
      msfr_mem_model_inst.ram[16'h0084 + i] = dat[i];
    end
    service(SVC_PROG, 16'h0080);
    for (int i = 0; i < 8; i++) check(msfr_mem_model_inst.flash[16'hEF3C + i], dat[i]);
    check(msfr_mem_model_inst.flash[16'hEF44], BLANK_BYTE);
    block(16'h00A0, 8'd8, 16'hEF3C);
    service(SVC_LOAD, 16'h00A0);
    for (int i = 0; i < 8; i++) check(msfr_mem_model_inst.ram[16'h00A4 + i], dat[i]);
    check(msfr_mem_model_inst.ram[16'h00AC], 8'h00);
    block(16'h00C0, 8'($urandom), 16'hEF17);
    service(SVC_ERASE, 16'h00C0);
    check(msfr_mem_model_inst.flash[16'hEF3C], BLANK_BYTE);
    for (int i = 0; i < 4; i++) check(msfr_mem_model_inst.flash[16'hEF40 + i], dat[4 + i]);
    reg_rd(REG_SVC_STATUS);
    check(rv[0], 1'b0);
    block(16'h00C0, 8'h00, MASS_ERASE_ADDR);
    service(SVC_ERASE, 16'h00C0);
    for (int i = 0; i < 8; i++)
      check(msfr_mem_model_inst.flash[SEC_FIRST_ADDR + i], BLANK_BYTE);
    check(msfr_mem_model_inst.flash[16'hEF40], BLANK_BYTE);
    $display("test services done");
    end_sim();
  end
endmodule : monitor_security_flash_routines_bench
